/* hsb_bus_agent.sv */
/*
  far-side bus agent: external drivers on the four open-drain pins.
  assumes pull-ups on every line, so a released line reads high.
*/
module hsb_bus_agent
  import hsb_pkg::*;
(
  input  wire logic      clk,
  input  wire hsb_pins_t oe,
  output hsb_pins_t      lvl
);
  hsb_pins_t ext = 4'h0; // one buffer on the path
  // wired-and of pull-up, agent lows and device lows
  assign lvl = ~(ext | oe);
  task automatic drive(input hsb_pins_t v);
    @(posedge clk) ext <= v;
  endtask : drive
  // start with clock low, then stop: data rises while clock high
  task automatic stop();
    drive(4'hc);
    repeat (4) @(posedge clk);
    drive(4'h8);
    repeat (4) @(posedge clk);
    drive(4'h0);
  endtask : stop
endmodule : hsb_bus_agent

/* hsb_ctrl.sv */
/*
  Connect controller of a hot-swap two-wire bus buffer: start-up
  sequencing, stop/idle detection, pair coupling with pull-down hold,
  accelerator enable and ready flag.
  Assumes pin levels are digital comparator outputs (falling edge seen
  below the upper threshold with adequate slew, rising edge seen above
  the accelerator threshold), asynchronous to MCLK and synchronised here.
  Open-drain pins: OE high means this block pulls the pin low.
*/
// Functional notes
// - While supply is under-voltage the sides stay apart and all four pins float.
// - Enable low forces the disconnected low-current state whatever the bus does.
// - Power-up with enable high, or enable rising, starts an initialization phase with precharge on.
// - The stop/idle detector is armed only after initialization ends.
// - Sides are joined when all pins stay high for the idle time, or all are high and a backplane STOP is seen.
// - Precharge runs from initialization until the connection is made.
// - During precharge each pin is weakly pulled toward 1 V through its own resistor.
// - Once connected, a low forced on one pin of a pair drives the other pin of that pair low.
// - A falling edge counts only below 0.7 of supply with at least 1.25 V/us slew.
// - With both pins of a pair low, the driven pin is held low only until the source pin's external driver releases.
// - A rising pin with adequate slew past 0.6 V turns the pull-down off and the accelerator on.
// - Ready stays low while disabled or not started and goes high once connected.
// - Enable low also turns off accelerators and precharge.
// - After enable returns, reconnection waits for traffic on both sides to finish.
module hsb_ctrl
  import hsb_pkg::*;
#(
  parameter int unsigned IDLE_CNT = IDLE_CYCLES
) (
  input  wire logic MCLK,
  input  wire logic SRST,
  input  wire logic UVLO_OK,
  input  wire logic ENABLE,
  input  wire logic BP_DATA_IN,
  input  wire logic BP_CLK_IN,
  input  wire logic CARD_DATA_IN,
  input  wire logic CARD_CLK_IN,
  output logic      BP_DATA_OE,
  output logic      BP_CLK_OE,
  output logic      CARD_DATA_OE,
  output logic      CARD_CLK_OE,
  output logic      PRECHARGE_EN,
  output logic      ACCEL_EN,
  output logic      READY_OE
);

  // two-stage synchronisers for all asynchronous inputs
  logic [5:0] s1_ff;
  logic [5:0] s2_ff;
  wire  [5:0] raw_in = {UVLO_OK, ENABLE, BP_DATA_IN, BP_CLK_IN, CARD_DATA_IN, CARD_CLK_IN};

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      // first stage must match the second: a 1 here would leak a
      // one-cycle enable/supply-good pulse just after reset release
      s1_ff <= 6'h0f;
      s2_ff <= 6'h0f;
    end else begin
      s1_ff <= raw_in;
      s2_ff <= s1_ff;
    end
  end

  hsb_pins_t pins;
  hsb_pins_t pins_ff;
  wire pwr_ok = s2_ff[5];
  wire en     = s2_ff[4];
  assign pins = s2_ff[3:0];

  // previous sample for edge and stop detection
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pins_ff <= '1;
    end else begin
      pins_ff <= pins;
    end
  end

  function automatic logic all_high(input hsb_pins_t p);
    all_high = p.bp_data & p.bp_clk & p.card_data & p.card_clk;
  endfunction : all_high

  // stop: backplane data rises while backplane clock stays high
  wire stop_seen = pins.bp_data & ~pins_ff.bp_data & pins.bp_clk & pins_ff.bp_clk;
  wire bus_high  = all_high(pins);
  wire active    = pwr_ok & en;

  hsb_state_t state_ff;
  hsb_state_t nxt_state;
  logic [CNT_W-1:0] init_cnt_ff;
  logic [CNT_W-1:0] idle_cnt_ff;
  logic [CNT_W-1:0] nxt_init_cnt;
  logic [CNT_W-1:0] nxt_idle_cnt;

  wire init_done = (init_cnt_ff >= CNT_W'(INIT_CYCLES));
  wire idle_done = (idle_cnt_ff >= CNT_W'(IDLE_CNT));
  wire join_now  = bus_high & (idle_done | stop_seen);

  // init counter runs only in the initialization state
  assign nxt_init_cnt = (state_ff == HSB_INIT) ? init_cnt_ff + CNT_W'(1) : '0;
  // idle timer: any low pin clears it, saturates at terminal count
  assign nxt_idle_cnt = (state_ff != HSB_ARMED || !bus_high) ? '0 :
                        (idle_done ? idle_cnt_ff : idle_cnt_ff + CNT_W'(1));

  // start-up sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      HSB_OFF:   if (active) nxt_state = HSB_INIT;
      HSB_INIT:  if (!active) nxt_state = HSB_OFF;
                 else if (init_done) nxt_state = HSB_ARMED;
      HSB_ARMED: if (!active) nxt_state = HSB_OFF;
                 else if (join_now) nxt_state = HSB_CONN;
      HSB_CONN:  if (!active) nxt_state = HSB_OFF;
      default:   nxt_state = HSB_OFF;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state_ff    <= HSB_OFF;
      init_cnt_ff <= '0;
      idle_cnt_ff <= '0;
    end else begin
      state_ff    <= nxt_state;
      init_cnt_ff <= nxt_init_cnt;
      idle_cnt_ff <= nxt_idle_cnt;
    end
  end

  // pair coupling: which side originated a low, held until that source pin reads high
  // hold_x[0]: backplane pin is the source, card pin is driven
  // hold_x[1]: card pin is the source, backplane pin is driven
  logic [1:0] hold_d_ff;
  logic [1:0] hold_c_ff;
  logic [1:0] nxt_hold_d;
  logic [1:0] nxt_hold_c;
  // release blanking: after we let go of a driven pin it still reads low
  // through the synchroniser for a couple of samples; without a guard that
  // stale low would start a reverse hold and lock the pair low for ever
  logic [1:0] blank_d_ff;
  logic [1:0] blank_c_ff;
  logic [1:0] nxt_blank_d;
  logic [1:0] nxt_blank_c;
  wire connected = (state_ff == HSB_CONN) & active;

  // a pin we drive reads low too, so only an unheld pin can start a hold;
  // release once the source pin is seen high again (rising past threshold)
  function automatic logic [1:0] pair_hold(input logic [1:0] h, input logic bp, input logic cd,
                                           input logic on, input logic hush);
    logic [1:0] r;
    r = h;
    if (!on) begin
      r = 2'h0;
    end else begin
      if (h[0] && bp) r[0] = 1'b0;
      if (h[1] && cd) r[1] = 1'b0;
      if (h == 2'h0 && !hush && !bp) r[0] = 1'b1;
      else if (h == 2'h0 && !hush && !cd) r[1] = 1'b1;
    end
    pair_hold = r;
  endfunction : pair_hold

  assign nxt_hold_d = pair_hold(hold_d_ff, pins.bp_data, pins.card_data, connected, |blank_d_ff);
  assign nxt_hold_c = pair_hold(hold_c_ff, pins.bp_clk, pins.card_clk, connected, |blank_c_ff);
  // a release event opens a two-sample window matching the sync latency
  assign nxt_blank_d = {blank_d_ff[0], (hold_d_ff != 2'h0) && (nxt_hold_d == 2'h0)};
  assign nxt_blank_c = {blank_c_ff[0], (hold_c_ff != 2'h0) && (nxt_hold_c == 2'h0)};

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      hold_d_ff  <= 2'h0;
      hold_c_ff  <= 2'h0;
      blank_d_ff <= 2'h0;
      blank_c_ff <= 2'h0;
    end else begin
      hold_d_ff  <= nxt_hold_d;
      hold_c_ff  <= nxt_hold_c;
      blank_d_ff <= nxt_blank_d;
      blank_c_ff <= nxt_blank_c;
    end
  end

  // registered pin drivers and status outputs
  wire nxt_prechg = active & ((state_ff == HSB_INIT) | (state_ff == HSB_ARMED));
  wire nxt_accel  = connected;
  wire nxt_ready  = ~connected;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      BP_DATA_OE   <= 1'b0;
      BP_CLK_OE    <= 1'b0;
      CARD_DATA_OE <= 1'b0;
      CARD_CLK_OE  <= 1'b0;
      PRECHARGE_EN <= 1'b0;
      ACCEL_EN     <= 1'b0;
      READY_OE     <= 1'b1;
    end else begin
      BP_DATA_OE   <= nxt_hold_d[1];
      CARD_DATA_OE <= nxt_hold_d[0];
      BP_CLK_OE    <= nxt_hold_c[1];
      CARD_CLK_OE  <= nxt_hold_c[0];
      PRECHARGE_EN <= nxt_prechg;
      ACCEL_EN     <= nxt_accel;
      READY_OE     <= nxt_ready;
    end
  end

endmodule : hsb_ctrl

/* hsb_ctrl_assertions.sv */
/*
  port checker for the connect controller.
  assumes binding to every hsb_ctrl instance.
*/
module hsb_ctrl_chk
  import hsb_pkg::*;
(
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic UVLO_OK,
  input wire logic ENABLE,
  input wire logic BP_DATA_IN,
  input wire logic BP_CLK_IN,
  input wire logic CARD_DATA_IN,
  input wire logic CARD_CLK_IN,
  input wire logic BP_DATA_OE,
  input wire logic BP_CLK_OE,
  input wire logic CARD_DATA_OE,
  input wire logic CARD_CLK_OE,
  input wire logic PRECHARGE_EN,
  input wire logic ACCEL_EN,
  input wire logic READY_OE
);
  default clocking dc @(posedge MCLK); endclocking
  default disable iff (SRST);
  logic [15:0] pc_ff;
  logic [15:0] nxt_pc;
  // run length of precharge, proves init came before connect
  assign nxt_pc = PRECHARGE_EN ? pc_ff + 16'h1 : 16'h0;
  always_ff @(posedge MCLK) pc_ff <= SRST ? 16'h0 : nxt_pc;
  sequence s_bp_low;
    $fell(BP_DATA_IN) ##1 !BP_DATA_IN [*2];
  endsequence
  property p_uvlo; !UVLO_OK [*5] |-> READY_OE && !(BP_DATA_OE | BP_CLK_OE | CARD_DATA_OE | CARD_CLK_OE); endproperty
  a_uvlo: assert property (p_uvlo) else $error("pins driven under low supply");
  property p_dis; !ENABLE [*5] |-> READY_OE && !ACCEL_EN && !PRECHARGE_EN; endproperty
  a_dis: assert property (p_dis) else $error("disable not honoured");
  property p_pre; ACCEL_EN |-> !PRECHARGE_EN; endproperty
  a_pre: assert property (p_pre) else $error("precharge on while joined");
  property p_rdy; ACCEL_EN == !READY_OE; endproperty
  a_rdy: assert property (p_rdy) else $error("ready flag off state");
  property p_init; $rose(ACCEL_EN) |-> pc_ff >= INIT_CYCLES; endproperty
  a_init: assert property (p_init) else $error("joined before init end");
  property p_join; $rose(ACCEL_EN) |-> BP_CLK_IN && CARD_DATA_IN && CARD_CLK_IN; endproperty
  a_join: assert property (p_join) else $error("joined on busy bus");
  property p_fwd; ACCEL_EN && CARD_DATA_IN ##0 s_bp_low |-> ##1 CARD_DATA_OE; endproperty
  a_fwd: assert property (p_fwd) else $error("data low not passed on");
  property p_hold; $fell(CARD_DATA_OE) && ACCEL_EN |-> $past(BP_DATA_IN, 3); endproperty
  a_hold: assert property (p_hold) else $error("drive dropped early");
endmodule : hsb_ctrl_chk
bind hsb_ctrl hsb_ctrl_chk u_chk (.*);

/* hsb_pkg.sv */
/*
  Package for the hot-swap bus connect controller: timing constants,
  state enumeration and the pin-group struct.
  Assumes a 20 MHz core clock; all pin levels arrive as digital samples.
*/
package hsb_pkg;

  localparam int unsigned CLK_HZ        = 20000000;
  // settling time of references and precharge after enable, in ns
  localparam int unsigned INIT_TIME_NS  = 1000;
  localparam int unsigned INIT_CYCLES   = (INIT_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // bus idle time in ns (terminal count of the idle timer)
  localparam int unsigned IDLE_TIME_NS  = 50000;
  localparam int unsigned IDLE_CYCLES   = (IDLE_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CNT_W         = 16;
  localparam logic [1:0]  SYNC_RST      = 2'h3;

  typedef enum logic [1:0] {
    HSB_OFF,
    HSB_INIT,
    HSB_ARMED,
    HSB_CONN
  } hsb_state_t;

  // one sample of the four bus pins
  typedef struct packed {
    logic bp_data;
    logic bp_clk;
    logic card_data;
    logic card_clk;
  } hsb_pins_t;

endpackage : hsb_pkg

/* tb_top.sv */
/*
  self-checking bench for the connect controller.
  assumes the bus agent model and the bound port checker.
*/
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] %s exp %0h got %0h", nm, e, a); end end
module tb_top;
  import hsb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned IC = 20; // short idle count for sim
  logic      mclk = 1'b0;
  logic      srst = 1'b1;
  logic      uvlo_ok = 1'b0;
  logic      enable = 1'b0;
  logic      pre, acc, rdy_oe;
  wire hsb_pins_t oe;
  wire hsb_pins_t lvl;
  int        n_fail = 0;
  int        n_tests = 0;
  int        cyc = 0;
  always #25 mclk = ~mclk;
  hsb_bus_agent u_bus (.clk(mclk), .oe(oe), .lvl(lvl));
  hsb_ctrl #(.IDLE_CNT(IC)) u_dut (.MCLK(mclk), .SRST(srst), .UVLO_OK(uvlo_ok), .ENABLE(enable),
    .BP_DATA_IN(lvl.bp_data), .BP_CLK_IN(lvl.bp_clk), .CARD_DATA_IN(lvl.card_data), .CARD_CLK_IN(lvl.card_clk),
    .BP_DATA_OE(oe.bp_data), .BP_CLK_OE(oe.bp_clk), .CARD_DATA_OE(oe.card_data), .CARD_CLK_OE(oe.card_clk),
    .PRECHARGE_EN(pre), .ACCEL_EN(acc), .READY_OE(rdy_oe));
  task automatic conclude();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic wait_acc(input int n);
    repeat (n) if (!acc) @(posedge mclk);
  endtask : wait_acc
  // power up on a busy backplane, join at its stop
  task automatic t_stop();
    u_bus.drive(4'h4);
    @(posedge mclk) {uvlo_ok, enable} <= 2'h3;
    repeat (6) @(posedge mclk);
    `CHK("pre", 1'b1, pre)
    repeat (40) @(posedge mclk);
    `CHK("acc", 1'b0, acc)
    u_bus.stop();
    wait_acc(10); // well under the idle count
    `CHK("acc", 1'b1, acc)
    `CHK("pre", 1'b0, pre)
    `CHK("rdy", 1'b0, rdy_oe)
    $display("t_stop end");
  endtask : t_stop
  // pair coupling, acknowledge overlap and clock pair
  task automatic t_pair();
    u_bus.drive(4'h8);
    repeat (5) @(posedge mclk);
    `CHK("cd_oe", 1'b1, oe.card_data)
    u_bus.drive(4'ha);
    u_bus.drive(4'h2);
    repeat (10) @(posedge mclk);
    `CHK("bp_lvl", 1'b0, lvl.bp_data)
    u_bus.drive(4'h1);
    repeat (5) @(posedge mclk);
    `CHK("bc_oe", 1'b1, oe.bp_clk)
    u_bus.drive(4'h0);
    repeat (8) @(posedge mclk);
    `CHK("lvl", 4'hf, lvl)
    $display("t_pair end");
  endtask : t_pair
  // disable, then re-enable while the backplane clock is held
  task automatic t_dis();
    @(posedge mclk) enable <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK("off", 3'h4, {rdy_oe, acc, pre})
    u_bus.drive(4'h4);
    @(posedge mclk) enable <= 1'b1;
    repeat (60) @(posedge mclk);
    `CHK("busy", 3'h5, {rdy_oe, acc, pre})
    u_bus.drive(4'h0);
    wait_acc(IC + 10);
    `CHK("acc", 1'b1, acc)
    $display("t_dis end");
  endtask : t_dis
  // supply loss releases every pin
  task automatic t_uvlo();
    u_bus.drive(4'h8);
    @(posedge mclk) uvlo_ok <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK("oe", 4'h0, oe)
    `CHK("rdy", 1'b1, rdy_oe)
    $display("t_uvlo end");
  endtask : t_uvlo
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK("rdy", 1'b1, rdy_oe)
    t_stop();
    t_pair();
    t_dis();
    t_uvlo();
    conclude();
  end
endmodule : tb_top
